// file: hw/gafs_defs.vh
// constants for the gpio alternate function select block
`ifndef GAFS_DEFS_VH
`define GAFS_DEFS_VH
`define GAFS_IDX_SEL_ONE 8'h44
`define GAFS_IDX_SEL_TWO 8'h45
`define GAFS_IDX_SEL_THREE 8'h46
`define GAFS_RST_SEL_ONE 8'h00
`define GAFS_RST_SEL_TWO 8'h50
`define GAFS_RST_SEL_THREE 8'h00
`define GAFS_MASK_SEL_ONE 8'hfc
`define GAFS_MASK_SEL_TWO 8'hf0
`define GAFS_MASK_SEL_THREE 8'hff
`define GAFS_F_LO 2
`define GAFS_F_MID 4
`define GAFS_F_HI 6
`define GAFS_F_BASE 0
`define GAFS_CODE_GPIO 2'b00
`define GAFS_CODE_ALT_A 2'b01
`define GAFS_CODE_ALT_B 2'b10
`endif

// file: hw/gafs_edge_det.v
// both-edge event detector for a synchronous input
`timescale 1ns/1ns
module gafs_edge_det #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    // signal
    input wire [WIDTH-1:0] sig_in,
    input wire [WIDTH-1:0] enable,
    output wire [WIDTH-1:0] event_pulse
);
    reg [WIDTH-1:0] last;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            last <= {WIDTH{1'b0}};
        end else if (clk_en) begin
            last <= sig_in;
        end
    end
    // rising or falling both count
    assign event_pulse = (sig_in ^ last) & enable & {WIDTH{clk_en}}; // R6
endmodule

// file: hw/gafs_pin_mux.v
// gpio alternate function select registers and pin routing
//
// Contract
// [R1] access only in config state, matching index
// [R2] first and third load zero on standby reset
// [R3] second loads 0x50; upper nibble also main/hard
// [R4] pin_one_one: gpio, density, powerdown flag
// [R5] software sets powerdown pin as input
// [R6] powerdown event on both edges
// [R7] pin_one_two: gpio or mgmt interrupt out
// [R8] mgmt interrupt active low, open drain selectable
// [R9] pin_one_three: gpio, irq input one, indicator
// [R10] software sets direction, polarity per function
// [R11] pin_one_six: gpio or address line twenty
// [R12] pin_one_seven: gpio or address line nineteen
// [R13] pin_two_one: gpio, infrared tx, watchdog
// [R14] pin_two_two: gpio, mode pin, chip select
// [R15] mode pin function from separate register
// [R16] pin_two_three: gpio, indicator two, irq two
// [R17] reserved bits ignore writes, read zero
// [R18] pin_two_zero code zero means gpio
`timescale 1ns/1ns
`include "gafs_defs.vh"
module gafs_pin_mux (
    // clock, enable and resets
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    input wire main_power_on_reset,
    input wire hard_reset,
    // configuration access
    input wire config_state,
    input wire [7:0] config_index_register,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_wdata,
    output reg [7:0] cfg_rdata,
    output wire cfg_hit,
    // gpio side per pin, order 11,12,13,16,17,20,21,22,23
    input wire [8:0] gpio_out,
    input wire [8:0] gpio_oe,
    output wire [8:0] gpio_in,
    // pins
    input wire [8:0] pin_i,
    output reg [8:0] pin_o,
    output reg [8:0] pin_oe,
    // alternate functions
    input wire drive_density_out_one,
    output wire floppy_powerdown_flag,
    output wire floppy_powerdown_event,
    input wire powerdown_event_en,
    input wire mgmt_interrupt_out_n,
    input wire output_type_register,
    output wire routable_irq_in_one,
    output wire routable_irq_in_two,
    input wire indicator_driver_one,
    input wire indicator_driver_two,
    input wire xbus_addr_line_twenty,
    input wire xbus_addr_line_nineteen,
    input wire infrared_tx_two,
    input wire watchdog_out,
    input wire mode_pin_config_register,
    input wire infrared_mode_function,
    input wire ir_perf_mode_alt,
    input wire xbus_chip_select_two_n,
    input wire powerdown_polarity,
    // select fields seen by the rest of the chip
    output wire [7:0] alt_sel_one,
    output wire [7:0] alt_sel_two,
    output wire [7:0] alt_sel_three
);
    // ------------------------------------------------
    // select registers
    // ------------------------------------------------
    reg [7:0] alt_func_select_one;
    reg [7:0] alt_func_select_two;
    reg [7:0] alt_func_select_three;
    wire hit_one = config_state &&
        config_index_register == `GAFS_IDX_SEL_ONE; // R1
    wire hit_two = config_state &&
        config_index_register == `GAFS_IDX_SEL_TWO; // R1
    wire hit_three = config_state &&
        config_index_register == `GAFS_IDX_SEL_THREE; // R1
    assign cfg_hit = hit_one | hit_two | hit_three;
    // default of the second register, upper nibble reloaded on resets
    wire [7:0] rst_two_val = `GAFS_RST_SEL_TWO;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            alt_func_select_one <= `GAFS_RST_SEL_ONE; // R2
            alt_func_select_two <= `GAFS_RST_SEL_TWO; // R3
            alt_func_select_three <= `GAFS_RST_SEL_THREE; // R2
        end else if (clk_en) begin
            if (main_power_on_reset || hard_reset) begin
                alt_func_select_two[7:4] <= rst_two_val[7:4]; // R3
            end else if (cfg_wr && hit_two) begin
                alt_func_select_two <= cfg_wdata & `GAFS_MASK_SEL_TWO; // R17
            end
            if (cfg_wr && hit_one) begin
                alt_func_select_one <= cfg_wdata & `GAFS_MASK_SEL_ONE; // R17
            end
            if (cfg_wr && hit_three) begin
                alt_func_select_three <= cfg_wdata;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (cfg_rd && hit_one) begin
                cfg_rdata <= alt_func_select_one; // R1
            end else if (cfg_rd && hit_two) begin
                cfg_rdata <= alt_func_select_two;
            end else if (cfg_rd && hit_three) begin
                cfg_rdata <= alt_func_select_three;
            end else if (cfg_rd) begin
                cfg_rdata <= 8'h00;
            end
        end
    end

    assign alt_sel_one = alt_func_select_one;
    assign alt_sel_two = alt_func_select_two;
    assign alt_sel_three = alt_func_select_three;

    // ------------------------------------------------
    // field decode
    // ------------------------------------------------
    wire [1:0] f11 = alt_func_select_one[`GAFS_F_LO+1:`GAFS_F_LO];
    wire [1:0] f12 = alt_func_select_one[`GAFS_F_MID+1:`GAFS_F_MID];
    wire [1:0] f13 = alt_func_select_one[`GAFS_F_HI+1:`GAFS_F_HI];
    wire [1:0] f16 = alt_func_select_two[`GAFS_F_MID+1:`GAFS_F_MID];
    wire [1:0] f17 = alt_func_select_two[`GAFS_F_HI+1:`GAFS_F_HI];
    wire [1:0] f20 = alt_func_select_three[`GAFS_F_BASE+1:`GAFS_F_BASE];
    wire [1:0] f21 = alt_func_select_three[`GAFS_F_LO+1:`GAFS_F_LO];
    wire [1:0] f22 = alt_func_select_three[`GAFS_F_MID+1:`GAFS_F_MID];
    wire [1:0] f23 = alt_func_select_three[`GAFS_F_HI+1:`GAFS_F_HI];
    wire [8:0] is_gpio;
    assign is_gpio = {f23 == `GAFS_CODE_GPIO, f22 == `GAFS_CODE_GPIO,
        f21 == `GAFS_CODE_GPIO, f20 == `GAFS_CODE_GPIO,
        f17 == `GAFS_CODE_GPIO, f16 == `GAFS_CODE_GPIO,
        f13 == `GAFS_CODE_GPIO, f12 == `GAFS_CODE_GPIO,
        f11 == `GAFS_CODE_GPIO};

    // inputs reach the gpio logic only in gpio mode
    assign gpio_in = pin_i & is_gpio;

    // ------------------------------------------------
    // input functions
    // ------------------------------------------------
    wire pd_sel = f11 == `GAFS_CODE_ALT_B;
    // pin is an input here; polarity bit sets sense
    assign floppy_powerdown_flag =
        pd_sel & (pin_i[0] ^ powerdown_polarity); // R5
    assign routable_irq_in_one = (f13 == `GAFS_CODE_ALT_A) & pin_i[2]; // R9
    assign routable_irq_in_two = (f23 == `GAFS_CODE_ALT_B) & pin_i[8]; // R16

    gafs_edge_det #(
        .WIDTH(1)
    ) u_pd_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .sig_in(floppy_powerdown_flag),
        .enable(pd_sel & powerdown_event_en),
        .event_pulse(floppy_powerdown_event)
    );

    // ------------------------------------------------
    // output routing
    // ------------------------------------------------
    wire mode_pin_val = mode_pin_config_register ?
        ir_perf_mode_alt : infrared_mode_function; // R15
    always @* begin
        pin_o = gpio_out;
        pin_oe = gpio_oe;
        case (f11) // R4
            `GAFS_CODE_ALT_A: begin
                pin_o[0] = drive_density_out_one;
                pin_oe[0] = 1'b1;
            end
            `GAFS_CODE_ALT_B: pin_oe[0] = 1'b0;
            `GAFS_CODE_GPIO: pin_oe[0] = gpio_oe[0];
            default: pin_oe[0] = 1'b0;
        endcase
        if (f12 == `GAFS_CODE_ALT_A) begin // R7
            // open drain drives only the low level
            pin_o[1] = mgmt_interrupt_out_n; // R8
            pin_oe[1] = !output_type_register | !mgmt_interrupt_out_n; // R8
        end else if (f12 != `GAFS_CODE_GPIO) begin
            pin_oe[1] = 1'b0;
        end
        case (f13) // R9
            `GAFS_CODE_ALT_A: pin_oe[2] = 1'b0;
            `GAFS_CODE_ALT_B: begin
                pin_o[2] = indicator_driver_one;
                pin_oe[2] = 1'b1;
            end
            `GAFS_CODE_GPIO: pin_oe[2] = gpio_oe[2];
            default: pin_oe[2] = 1'b0;
        endcase
        if (f16 == `GAFS_CODE_ALT_A) begin // R11
            pin_o[3] = xbus_addr_line_twenty;
            pin_oe[3] = 1'b1;
        end else if (f16 != `GAFS_CODE_GPIO) begin
            pin_oe[3] = 1'b0;
        end
        if (f17 == `GAFS_CODE_ALT_A) begin // R12
            pin_o[4] = xbus_addr_line_nineteen;
            pin_oe[4] = 1'b1;
        end else if (f17 != `GAFS_CODE_GPIO) begin
            pin_oe[4] = 1'b0;
        end
        if (f20 != `GAFS_CODE_GPIO) begin // R18
            pin_oe[5] = 1'b0;
        end
        case (f21) // R13
            `GAFS_CODE_ALT_A: begin
                pin_o[6] = infrared_tx_two;
                pin_oe[6] = 1'b1;
            end
            `GAFS_CODE_ALT_B: begin
                pin_o[6] = watchdog_out;
                pin_oe[6] = 1'b1;
            end
            `GAFS_CODE_GPIO: pin_oe[6] = gpio_oe[6];
            default: pin_oe[6] = 1'b0;
        endcase
        case (f22) // R14
            `GAFS_CODE_ALT_A: begin
                pin_o[7] = mode_pin_val;
                pin_oe[7] = 1'b1;
            end
            `GAFS_CODE_ALT_B: begin
                pin_o[7] = xbus_chip_select_two_n;
                pin_oe[7] = 1'b1;
            end
            `GAFS_CODE_GPIO: pin_oe[7] = gpio_oe[7];
            default: pin_oe[7] = 1'b0;
        endcase
        case (f23) // R16
            `GAFS_CODE_ALT_A: begin
                pin_o[8] = indicator_driver_two;
                pin_oe[8] = 1'b1;
            end
            `GAFS_CODE_ALT_B: pin_oe[8] = 1'b0;
            `GAFS_CODE_GPIO: pin_oe[8] = gpio_oe[8];
            default: pin_oe[8] = 1'b0;
        endcase
    end
endmodule

// file: verif/gafs_pin_mux_sva.sv
// assertions for the alternate function select block
`timescale 1ns/1ns
module gafs_pin_mux_sva (
    // clock and resets
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    input wire main_power_on_reset,
    input wire hard_reset,
    // configuration access
    input wire config_state,
    input wire [7:0] config_index_register,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_rdata,
    input wire cfg_hit,
    // pins and functions
    input wire [8:0] pin_o,
    input wire [8:0] pin_oe,
    input wire mgmt_interrupt_out_n,
    input wire output_type_register,
    input wire xbus_addr_line_twenty,
    input wire floppy_powerdown_flag,
    input wire floppy_powerdown_event,
    input wire powerdown_event_en,
    input wire [7:0] alt_sel_one,
    input wire [7:0] alt_sel_two,
    input wire [7:0] alt_sel_three
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
wire [7:0] idx = config_index_register;
wire idx_ok = idx == 8'h44 || idx == 8'h45 || idx == 8'h46;
a_reserved_zero: assert property (
    alt_sel_one[1:0] == 2'b00 && alt_sel_two[3:0] == 4'h0)
    else $error("reserved select bits not zero");
a_hit_decode: assert property (cfg_hit == (config_state && idx_ok))
    else $error("config hit decode wrong");
a_miss_read_zero: assert property (
    clk_en && cfg_rd && !cfg_hit |=> cfg_rdata == 8'h00)
    else $error("unmatched read not zero");
a_read_three: assert property (
    clk_en && cfg_rd && !cfg_wr && cfg_hit && idx == 8'h46
    |=> cfg_rdata == $past(alt_sel_three))
    else $error("read data of third select wrong");
a_miss_write_kept: assert property (
    clk_en && !cfg_hit && !main_power_on_reset && !hard_reset
    |=> $stable(alt_sel_one) && $stable(alt_sel_two)
    && $stable(alt_sel_three))
    else $error("select changed without access");
a_reset_values: assert property (
    $rose(rst_n) && $past(clk_en) |-> alt_sel_one == 8'h00
    && alt_sel_two == 8'h50 && alt_sel_three == 8'h00)
    else $error("select reset values wrong");
a_upper_reload: assert property (
    clk_en && (main_power_on_reset || hard_reset)
    |=> alt_sel_two[7:4] == 4'h5)
    else $error("address fields not reloaded");
a_mgmt_drive: assert property (alt_sel_one[5:4] == 2'b01
    |-> pin_o[1] == mgmt_interrupt_out_n && pin_oe[1] ==
    (!output_type_register || !mgmt_interrupt_out_n))
    else $error("management output drive wrong");
a_addr_twenty: assert property (alt_sel_two[5:4] == 2'b01
    |-> pin_o[3] == xbus_addr_line_twenty && pin_oe[3])
    else $error("address line twenty not driven");
a_pd_both_edges: assert property (
    clk_en && $past(clk_en) && powerdown_event_en
    && alt_sel_one[3:2] == 2'b10
    && $past(alt_sel_one[3:2]) == 2'b10
    && $changed(floppy_powerdown_flag)
    |-> ##[0:1] floppy_powerdown_event)
    else $error("powerdown edge gave no event");
endmodule
bind gafs_pin_mux gafs_pin_mux_sva i_sva (.clk_sys, .rst_n, .clk_en,
    .main_power_on_reset, .hard_reset, .config_state,
    .config_index_register, .cfg_wr, .cfg_rd, .cfg_rdata, .cfg_hit,
    .pin_o, .pin_oe, .mgmt_interrupt_out_n, .output_type_register,
    .xbus_addr_line_twenty, .floppy_powerdown_flag,
    .floppy_powerdown_event, .powerdown_event_en, .alt_sel_one,
    .alt_sel_two, .alt_sel_three);

// file: verif/test_gafs_pin_mux.sv
// testbench for the alternate function select block
`timescale 1ns/1ns
module test_gafs_pin_mux;
reg clk_sys = 0, rst_n = 0, clk_en = 1, config_state = 1;
reg main_power_on_reset = 0, hard_reset = 0, cfg_wr = 0, cfg_rd = 0;
reg [7:0] config_index_register = 8'h00, cfg_wdata = 8'h00;
reg [47:0] src = 48'h0000_0000_0000;
reg pd_prev = 1'b0;
integer fails = 0, n_compared = 0, cyc = 0;
wire [7:0] cfg_rdata, alt_sel_one, alt_sel_two, alt_sel_three;
wire [8:0] gpio_in, pin_o, pin_oe;
wire cfg_hit, floppy_powerdown_flag, floppy_powerdown_event;
wire routable_irq_in_one, routable_irq_in_two;
// every alternate source is a bit of a counter stepped on each falling edge
wire [8:0] gpio_out = src[8:0], gpio_oe = src[17:9], pin_i = src[26:18];
wire drive_density_out_one = src[27], mgmt_interrupt_out_n = src[28];
wire output_type_register = src[29], indicator_driver_one = src[30];
wire indicator_driver_two = src[31], xbus_addr_line_twenty = src[32];
wire xbus_addr_line_nineteen = src[33], infrared_tx_two = src[34];
wire watchdog_out = src[35], mode_pin_config_register = src[36];
wire infrared_mode_function = src[37], ir_perf_mode_alt = src[38];
wire xbus_chip_select_two_n = src[39], powerdown_polarity = src[40];
wire powerdown_event_en = src[41];
gafs_pin_mux i_dut (.clk_sys, .rst_n, .clk_en, .main_power_on_reset,
    .hard_reset, .config_state, .config_index_register, .cfg_wr,
    .cfg_rd, .cfg_wdata, .cfg_rdata, .cfg_hit, .gpio_out, .gpio_oe,
    .gpio_in, .pin_i, .pin_o, .pin_oe, .drive_density_out_one,
    .floppy_powerdown_flag, .floppy_powerdown_event, .powerdown_event_en,
    .mgmt_interrupt_out_n, .output_type_register, .routable_irq_in_one,
    .routable_irq_in_two, .indicator_driver_one, .indicator_driver_two,
    .xbus_addr_line_twenty, .xbus_addr_line_nineteen, .infrared_tx_two,
    .watchdog_out, .mode_pin_config_register, .infrared_mode_function,
    .ir_perf_mode_alt, .xbus_chip_select_two_n, .powerdown_polarity,
    .alt_sel_one, .alt_sel_two, .alt_sel_three);
always #20 clk_sys = ~clk_sys;
always @(negedge clk_sys) src <= src + 48'h9e37_79b9_7f4b;
always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
        fails = fails + 1;
        results;
    end
end
// ----------------------------------------
// compare and bus tasks
// ----------------------------------------
task chk(input [8:0] got, input [8:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
        fails = fails + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
    end
endtask
task chb(input got, input exp);
    chk({8'h00, got}, {8'h00, exp});
endtask
task wr(input [7:0] i, input [7:0] d);
    @(negedge clk_sys);
    config_index_register = i;
    cfg_wdata = d;
    cfg_wr = 1;
    @(negedge clk_sys);
    cfg_wr = 0;
endtask
task rd(input [7:0] i, input [7:0] e);
    @(negedge clk_sys);
    config_index_register = i;
    cfg_rd = 1;
    @(negedge clk_sys);
    cfg_rd = 0;
    chk({1'b0, cfg_rdata}, {1'b0, e});
endtask
task results;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_access;
    wr(8'h44, 8'hff);
    rd(8'h44, 8'hfc);
    wr(8'h45, 8'hff);
    rd(8'h45, 8'hf0);
    wr(8'h46, 8'hff);
    rd(8'h46, 8'hff);
    config_state = 0;
    wr(8'h46, 8'h00);
    rd(8'h46, 8'h00);
    config_state = 1;
    wr(8'h47, 8'h00);
    rd(8'h47, 8'h00);
    rd(8'h46, 8'hff);
endtask
// a reset pulse beats a write of zero in the same cycle
task t_reload(input m, input h);
    @(negedge clk_sys);
    config_index_register = 8'h45;
    cfg_wdata = 8'h00;
    cfg_wr = 1;
    main_power_on_reset = m;
    hard_reset = h;
    @(negedge clk_sys);
    cfg_wr = 0;
    main_power_on_reset = 0;
    hard_reset = 0;
    rd(8'h45, 8'h50);
endtask
task t_route;
    wr(8'h44, 8'h00);
    wr(8'h45, 8'h00);
    wr(8'h46, 8'h00);
    #1 chk(pin_o, gpio_out);
    chk(pin_oe, gpio_oe);
    chk(gpio_in, pin_i);
    wr(8'h44, 8'h54);
    wr(8'h45, 8'h50);
    wr(8'h46, 8'h54);
    #1 chb(pin_o[0], drive_density_out_one);
    chb(pin_o[1], mgmt_interrupt_out_n);
    chb(routable_irq_in_one, pin_i[2]);
    chb(pin_o[4], xbus_addr_line_nineteen);
    chb(pin_o[6], infrared_tx_two);
    chb(pin_o[7], mode_pin_config_register ? ir_perf_mode_alt
        : infrared_mode_function);
    chb(pin_o[8], indicator_driver_two);
    chb(pin_o[3], xbus_addr_line_twenty);
    chk(pin_oe, {3'b111, gpio_oe[5], 2'b11, 1'b0,
        ~output_type_register | ~mgmt_interrupt_out_n, 1'b1});
    chk(gpio_in, {3'b000, pin_i[5], 5'h00});
    wr(8'h44, 8'ha8);
    wr(8'h46, 8'ha8);
    #1 chb(floppy_powerdown_flag, pin_i[0] ^ powerdown_polarity);
    chb(pin_oe[0], 1'b0);
    chb(pin_o[2], indicator_driver_one);
    chb(pin_o[6], watchdog_out);
    chb(pin_o[7], xbus_chip_select_two_n);
    chb(routable_irq_in_two, pin_i[8]);
    chk(pin_oe, {1'b0, 2'b11, gpio_oe[5], 3'b111, 2'b00});
    // the flag is stable from one falling edge to the next
    repeat (20) begin
        pd_prev = floppy_powerdown_flag;
        @(negedge clk_sys);
        #1 chb(floppy_powerdown_event,
            (floppy_powerdown_flag ^ pd_prev) & powerdown_event_en);
    end
    wr(8'h46, 8'ha9);
    #1 chb(pin_oe[5], 1'b0);
    chb(gpio_in[5], 1'b0);
endtask
// a write while the clock enable is low is lost
task t_freeze;
    clk_en = 0;
    wr(8'h46, 8'h00);
    clk_en = 1;
    rd(8'h46, 8'ha9);
endtask
// a standby reset in mid-run restores every default
task t_standby;
    wr(8'h45, 8'h00);
    rd(8'h45, 8'h00);
    @(negedge clk_sys);
    rst_n = 0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1;
    rd(8'h44, 8'h00);
    rd(8'h45, 8'h50);
    rd(8'h46, 8'h00);
endtask
initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1;
    rd(8'h44, 8'h00);
    rd(8'h45, 8'h50);
    rd(8'h46, 8'h00);
    t_access;
    t_reload(1'b1, 1'b0);
    t_reload(1'b0, 1'b1);
    t_route;
    t_freeze;
    t_standby;
    results;
end
endmodule
